// >>> rtl/chg_supervisor.v
// charger supervision: bus timeout, watchdog, pin decode, power policy
// assumes Avalon-MM master on clk_sys and analog comparators outside
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "chg_map.vh"
module chg_supervisor #(
  parameter [6:0]  SMB_ADDR = 7'h2A, // arbitrary bus address
  parameter [31:0] TOUT_CYC = `CHG_TOUT_MS * `CHG_CLK_KHZ,
  parameter [31:0] WDT1_CYC = `CHG_WDT1_MS * `CHG_CLK_KHZ,
  parameter [31:0] WDT2_CYC = `CHG_WDT2_MS * `CHG_CLK_KHZ,
  parameter [31:0] WDT3_CYC = `CHG_WDT3_MS * `CHG_CLK_KHZ
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  output reg         irq,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        boost_output_enable_pin,
  input  wire        hiz_pin_below_low,
  input  wire        hiz_pin_above_high,
  input  wire [8:0]  cell_cmp,
  input  wire        adapter_present,
  input  wire        bat_above_uvlo,
  input  wire        charger_fault,
  input  wire        input_overload,
  input  wire        charge_current_zero,
  output reg         battery_pass_transistor,
  output reg         internal_regulator_output,
  output reg         hiz_mode,
  output reg         vap_active,
  output reg         supplement_mode,
  output reg         charge_current_reduce,
  output reg         minimum_system_voltage_loop,
  output reg  [11:0] vap_dac_code,
  output reg  [11:0] sys_setpoint,
  output reg  [3:0]  monitor_enable
);

  // bus slave states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_DATA = 3'h2;
  localparam [2:0] S_AWAIT = 3'h3;
  localparam [2:0] S_ACK = 3'h4;

  // byte-lane merge for narrow registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    reg   [31:0] m;
    begin
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // watchdog length from the period select code
  function [31:0] wdt_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'b01:   wdt_limit = WDT1_CYC;
        2'b10:   wdt_limit = WDT2_CYC;
        2'b11:   wdt_limit = WDT3_CYC;
        default: wdt_limit = 32'h0000_0000;
      endcase
    end
  endfunction

  wire [18:0] raw_in;
  wire [18:0] syn;
  assign raw_in = {charge_current_zero, input_overload, charger_fault,
                   bat_above_uvlo, adapter_present, cell_cmp,
                   hiz_pin_above_high, hiz_pin_below_low,
                   boost_output_enable_pin, sda_in, scl_in};

  chg_sync #(.W(19)) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  wire       scl_s    = syn[0];
  wire       sda_s    = syn[1];
  wire       vap_pin  = syn[2];
  wire       hiz_low  = syn[3];
  wire       hiz_high = syn[4];
  wire [8:0] cmp      = syn[13:5];
  wire       adp      = syn[14];
  wire       uvlo_ok  = syn[15];
  wire       fault    = syn[16];
  wire       ovl      = syn[17];
  wire       chg_zero = syn[18];

  reg [9:0]  ctrl;
  reg [11:0] vout;
  reg [6:0]  iout;
  reg [11:0] vsysmin;
  reg [`CHG_INT_W-1:0] int_stat;
  reg [`CHG_INT_W-1:0] int_mask;
  reg [2:0]  state;
  reg [3:0]  bitcnt;
  reg [7:0]  shreg;
  reg        is_data;
  reg        scl_d;
  reg        sda_d;
  reg [31:0] low_cnt;
  reg [31:0] wdt_cnt;
  reg        hiz_pin;
  reg        bat_present;
  reg [2:0]  cell_count;
  reg        wr_kick;
  reg        tout_ev;
  reg        hiz_d;

  wire        acc      = (read | write) & ~waitrequest;
  wire        wr_acc   = write & ~waitrequest;
  wire        rd_int   = read & ~waitrequest &
                         (address == `CHG_OFS_INT_STAT);
  wire        scl_rise = scl_s & ~scl_d;
  wire        scl_fall = ~scl_s & scl_d;
  wire        start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire        stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire [1:0]  wdt_sel  = ctrl[`CHG_CTL_WDT_HI:`CHG_CTL_WDT_LO];
  wire [31:0] wdt_lim  = wdt_limit(wdt_sel);
  wire        wdt_ev   = (wdt_sel != 2'b00) &&
                         (wdt_cnt >= wdt_lim - 32'd1);
  wire        vap_on   = vap_pin & ~ctrl[`CHG_CTL_MODE_SEL] & ~adp;
  wire        next_hiz = hiz_pin | ctrl[`CHG_CTL_HIZ_EN];
  reg  [31:0] rd_mux;
  reg  [2:0]  next_cells;
  reg  [`CHG_INT_W-1:0] ev;
  // write word merged with the old value, which rd_mux holds zero-padded
  wire [31:0] wr_mrg   = merge(rd_mux, writedata, byteenable);

  // bus handshake: one wait cycle, answer on the second edge
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest)
        readdata <= rd_mux;
    end
  end

  // read decode; unmapped offsets read zero
  always @* begin
    case (address)
      `CHG_OFS_CTRL:     rd_mux = {22'h0, ctrl};
      `CHG_OFS_VOUT:     rd_mux = {20'h0, vout};
      `CHG_OFS_IOUT:     rd_mux = {25'h0, iout};
      `CHG_OFS_VSYSMIN:  rd_mux = {20'h0, vsysmin};
      `CHG_OFS_STATUS:   rd_mux = {22'h0, state != S_IDLE,
                                   supplement_mode,
                                   internal_regulator_output,
                                   battery_pass_transistor, vap_active,
                                   hiz_mode, bat_present, cell_count};
      `CHG_OFS_INT_STAT: rd_mux = {27'h0, int_stat};
      `CHG_OFS_INT_MASK: rd_mux = {27'h0, int_mask};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // register writes; a fault forces mode select back over software
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= `CHG_CTL_RESET;
      vout     <= 12'h000;
      iout     <= 7'h00;
      vsysmin  <= 12'h000;
      int_mask <= {`CHG_INT_W{1'b0}};
    end else begin
      if (wr_acc) begin
        case (address)
          `CHG_OFS_CTRL:     ctrl     <= wr_mrg[9:0];
          `CHG_OFS_VOUT:     vout     <= wr_mrg[11:0];
          `CHG_OFS_IOUT:     iout     <= wr_mrg[6:0];
          `CHG_OFS_VSYSMIN:  vsysmin  <= wr_mrg[11:0];
          `CHG_OFS_INT_MASK: int_mask <= wr_mrg[`CHG_INT_W-1:0];
          default: ;
        endcase
      end
      if (fault)
        ctrl[`CHG_CTL_MODE_SEL] <= 1'b1;
    end
  end

  // sticky events; a set in the clearing read cycle survives
  always @* begin
    ev = {`CHG_INT_W{1'b0}};
    ev[`CHG_INT_TOUT]   = tout_ev;
    ev[`CHG_INT_WDT]    = wdt_ev;
    ev[`CHG_INT_BATCHG] = (cmp[`CHG_CMP_19] & ~bat_present) |
                          (cmp[`CHG_CMP_15] & bat_present);
    ev[`CHG_INT_HIZ]    = next_hiz & ~hiz_d;
    ev[`CHG_INT_VAPFLT] = fault & vap_active;
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_stat <= {`CHG_INT_W{1'b0}};
      irq      <= 1'b0;
      hiz_d    <= 1'b0;
    end else begin
      // clear only what the read returned; later sets stay pending
      int_stat <= (rd_int ? int_stat & ~readdata[`CHG_INT_W-1:0] :
                   int_stat) | ev;
      irq      <= |(int_stat & int_mask);
      hiz_d    <= next_hiz;
    end
  end

  // bus slave on sampled pins; we never hold the clock line low
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      state   <= S_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      is_data <= 1'b0;
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
      low_cnt <= 32'h0000_0000;
      tout_ev <= 1'b0;
      wr_kick <= 1'b0;
    end else begin
      scl_d   <= scl_s;
      sda_d   <= sda_s;
      sda_out <= 1'b0;
      tout_ev <= 1'b0;
      wr_kick <= 1'b0;
      // clock low supervision, cleared whenever the clock is high
      if (scl_s)
        low_cnt <= 32'h0000_0000;
      else if (low_cnt != TOUT_CYC)
        low_cnt <= low_cnt + 32'd1;
      if (!scl_s && low_cnt == TOUT_CYC - 32'd1) begin
        tout_ev <= 1'b1;
        sda_oe  <= 1'b0;
        state   <= S_IDLE;
      end else if (start_c) begin
        state  <= S_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_DATA: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                is_data <= (state == S_DATA);
                if (state == S_DATA ||
                    {shreg[6:0], sda_s} == {SMB_ADDR, 1'b0})
                  state <= S_AWAIT;
                else
                  state <= S_IDLE; // reads and other addresses
              end
            end
          end
          S_AWAIT: begin
            if (scl_fall) begin
              sda_oe <= 1'b1;
              state  <= S_ACK;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_oe  <= 1'b0;
              state   <= S_DATA;
              bitcnt  <= 4'h0;
              wr_kick <= is_data;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // watchdog; code 00 holds the count at zero
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      wdt_cnt <= 32'h0000_0000;
    else if (wdt_sel == 2'b00 || wr_kick || wdt_ev)
      wdt_cnt <= 32'h0000_0000;
    else
      wdt_cnt <= wdt_cnt + 32'd1;
  end

  // cell window decode; readings in a gap keep the last count
  always @* begin
    if (cmp[`CHG_CMP_76])
      next_cells = 3'd4;
    else if (cmp[`CHG_CMP_56] && !cmp[`CHG_CMP_74])
      next_cells = 3'd3;
    else if (cmp[`CHG_CMP_41] && !cmp[`CHG_CMP_54])
      next_cells = 3'd2;
    else if (cmp[`CHG_CMP_19P5] && !cmp[`CHG_CMP_39])
      next_cells = 3'd1;
    else
      next_cells = cell_count;
  end

  // hysteresis latches for the two analog pins
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hiz_pin     <= 1'b0;
      bat_present <= 1'b0;
      cell_count  <= 3'd0;
    end else begin
      if (hiz_low)
        hiz_pin <= 1'b1;
      else if (hiz_high)
        hiz_pin <= 1'b0;
      if (cmp[`CHG_CMP_19])
        bat_present <= 1'b1;
      else if (cmp[`CHG_CMP_15])
        bat_present <= 1'b0;
      cell_count <= next_cells;
    end
  end

  // power path policy, all outputs registered
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      battery_pass_transistor     <= 1'b0;
      internal_regulator_output   <= 1'b0;
      hiz_mode                    <= 1'b0;
      vap_active                  <= 1'b0;
      supplement_mode             <= 1'b0;
      charge_current_reduce       <= 1'b0;
      minimum_system_voltage_loop <= 1'b0;
      vap_dac_code                <= 12'h000;
      sys_setpoint                <= 12'h000;
      monitor_enable              <= 4'h0;
    end else begin
      hiz_mode <= next_hiz;
      // battery feeds the system alone, in hiz, or in supplement
      battery_pass_transistor <= (~adp & uvlo_ok) |
                                 next_hiz | (ovl & chg_zero);
      // regulator stays on in performance mode and in hiz
      internal_regulator_output <= ~ctrl[`CHG_CTL_LPM] |
                                   next_hiz | adp;
      // monitors only honoured in performance mode
      monitor_enable <= ctrl[`CHG_CTL_LPM] ? 4'h0 :
                        ctrl[`CHG_CTL_MON_HI:`CHG_CTL_MON_LO];
      vap_active <= vap_on & ~fault;
      charge_current_reduce <= ovl;
      supplement_mode <= ovl & chg_zero;
      minimum_system_voltage_loop <= vap_on & ~fault;
      sys_setpoint <= vsysmin;
      // offset only in the high range; the host orders the setup
      vap_dac_code <= ctrl[`CHG_CTL_LOW_RNG] ? vout :
                      vout + `CHG_VOUT_OFFSET;
    end
  end

endmodule

// >>> rtl/chg_map.vh
// register offsets, field positions, reset values and timing counts
// for the charger supervision block; definitions only, no logic.
// Summary of operation
// - clock low over 25ms resets bus within 35ms
// - master stretch 10ms, slave stretch 25ms maximum
// - period select 01/10/11 gives 4.8/77/153 s
// - high-impedance below 0.6V, leave above 0.83V
// - cell count decoded from regulator fraction
// - battery present above 19%, removed below 15%
// - no adapter, battery above lockout: pass transistor
// - battery-only start with low power bit set
// - low power bit 0 keeps regulator, allows monitors
// - low range bit 0 adds 1.28V output offset
// - protection mode regulates at minimum system voltage
// - overload cuts charge current, then supplement mode
// - mode select 0 with pin high enables protection; the code also requires no adapter
// - charger fault sets mode select back to 1
// - enable bit forces high-impedance, battery powers system
`ifndef CHG_MAP_VH
`define CHG_MAP_VH

// byte offsets on the register bus
`define CHG_OFS_CTRL      5'h00
`define CHG_OFS_VOUT      5'h04
`define CHG_OFS_IOUT      5'h08
`define CHG_OFS_VSYSMIN   5'h0C
`define CHG_OFS_STATUS    5'h10
`define CHG_OFS_INT_STAT  5'h14
`define CHG_OFS_INT_MASK  5'h18

// control register fields
`define CHG_CTL_LPM       0
`define CHG_CTL_HIZ_EN    1
`define CHG_CTL_MODE_SEL  2
`define CHG_CTL_LOW_RNG   3
`define CHG_CTL_WDT_LO    4
`define CHG_CTL_WDT_HI    5
`define CHG_CTL_MON_LO    6
`define CHG_CTL_MON_HI    9
`define CHG_CTL_RESET     10'h015

// interrupt bits
`define CHG_INT_TOUT      0
`define CHG_INT_WDT       1
`define CHG_INT_BATCHG    2
`define CHG_INT_HIZ       3
`define CHG_INT_VAPFLT    4
`define CHG_INT_W         5

// comparator vector positions of cell_cmp
`define CHG_CMP_76        0
`define CHG_CMP_74        1
`define CHG_CMP_56        2
`define CHG_CMP_54        3
`define CHG_CMP_41        4
`define CHG_CMP_39        5
`define CHG_CMP_19P5      6
`define CHG_CMP_19        7
`define CHG_CMP_15        8

// output offset of 1.28V in 8mV steps
`define CHG_VOUT_OFFSET   12'h0A0

// timing: clock rate and times in ms
`define CHG_CLK_KHZ       32'd20000
`define CHG_TOUT_MS       32'd25
`define CHG_WDT1_MS       32'd4800
`define CHG_WDT2_MS       32'd77000
`define CHG_WDT3_MS       32'd153000

`endif

// >>> rtl/chg_sync.v
// two-stage synchroniser bank for pins and analog comparator outputs
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module chg_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta;

  // first stage is read only by the second stage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> tb/chg_supervisor_monitor.sv
// checker for chg_supervisor policy outputs and bus release
// assumes the single clk_sys domain and the active-low resetn
`timescale 1ns/1ps
module chg_supervisor_monitor #(
  parameter [31:0] TOUT_CYC = 32'h7A120
) (
  input wire       clk_sys,
  input wire       resetn,
  input wire       scl_in,
  input wire       sda_oe,
  input wire       boost_output_enable_pin,
  input wire       hiz_pin_below_low,
  input wire       adapter_present,
  input wire       bat_above_uvlo,
  input wire       charger_fault,
  input wire       battery_pass_transistor,
  input wire       internal_regulator_output,
  input wire       hiz_mode,
  input wire       vap_active,
  input wire       supplement_mode,
  input wire       charge_current_reduce,
  input wire       minimum_system_voltage_loop,
  input wire [3:0] monitor_enable
);
  reg [31:0] low_cnt;
  reg        rst_q;

  default clocking mon_cb @(posedge clk_sys);
  endclocking
  // the release edge still sees flops in reset, so skip it too
  default disable iff (!rst_q);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= 1'b1;
    end
  end

  // length of the current clock-low stretch, saturating
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 32'h0;
    end else if (scl_in) begin
      low_cnt <= 32'h0;
    end else if (low_cnt != 32'hFFFFFFFF) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  // margin of four covers the two-stage pin synchroniser
  property p_tout_release;
    low_cnt > TOUT_CYC + 32'h4 |-> !sda_oe;
  endproperty
  a_tout_release: assert property (p_tout_release)
    else $error("data line held after bus timeout");

  // three edges from pin to policy output
  property p_batt_only;
    (!adapter_present && bat_above_uvlo) [*4] |-> battery_pass_transistor;
  endproperty
  a_batt_only: assert property (p_batt_only)
    else $error("pass transistor off on battery only");

  property p_mon_reg;
    (monitor_enable != 4'h0) [*2] |-> internal_regulator_output;
  endproperty
  a_mon_reg: assert property (p_mon_reg)
    else $error("monitors enabled with regulator off");

  property p_vsys_loop;
    vap_active && $past(vap_active) |-> minimum_system_voltage_loop;
  endproperty
  a_vsys_loop: assert property (p_vsys_loop)
    else $error("protection mode without minimum loop");

  property p_supplement;
    supplement_mode [*2] |-> charge_current_reduce && battery_pass_transistor;
  endproperty
  a_supplement: assert property (p_supplement)
    else $error("supplement without cut or pass transistor");

  property p_pin_end;
    (!boost_output_enable_pin) [*4] |-> !vap_active;
  endproperty
  a_pin_end: assert property (p_pin_end)
    else $error("protection mode with enable pin low");

  property p_fault_end;
    charger_fault [*4] |-> !vap_active;
  endproperty
  a_fault_end: assert property (p_fault_end)
    else $error("protection mode during a fault");

  // sync, latch and output register: four edges from pin to mode
  property p_hiz_enter;
    hiz_pin_below_low [*5] |-> hiz_mode;
  endproperty
  a_hiz_enter: assert property (p_hiz_enter)
    else $error("high impedance not entered");

  property p_hiz_power;
    hiz_mode [*2] |-> battery_pass_transistor && internal_regulator_output;
  endproperty
  a_hiz_power: assert property (p_hiz_power)
    else $error("high impedance without battery or regulator");
endmodule

bind chg_supervisor chg_supervisor_monitor #(.TOUT_CYC(TOUT_CYC))
  u_chg_supervisor_monitor (.clk_sys, .resetn, .scl_in, .sda_oe,
  .boost_output_enable_pin, .hiz_pin_below_low, .adapter_present,
  .bat_above_uvlo, .charger_fault, .battery_pass_transistor,
  .internal_regulator_output, .hiz_mode, .vap_active, .supplement_mode,
  .charge_current_reduce, .minimum_system_voltage_loop, .monitor_enable);

// >>> tb/chg_smb_host.sv
// bus host partner: write frames and a clock-low stall
// assumes a pull-up on the data wire; bit period 400 ns
`timescale 1ns/1ps
module chg_smb_host (
  output reg  scl,
  output reg  sda_low,
  input  wire sda_line
);
  reg ack;

  // clock stands high between frames
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // one bit: data set while clock low, sampled mid-high
  task clk_bit(input b);
    begin
      sda_low = !b;
      #100 scl = 1'h1;
      #100 ack = !sda_line;
      #100 scl = 1'h0;
      #100;
    end
  endtask

  // start, address with write bit, one data byte, stop
  task frame(input [6:0] a, input [7:0] d, output ok);
    reg [15:0] w;
    integer    k;
    begin
      #10; // keep pin changes off the sampling clock edges
      w = {a, 1'h0, d};
      ok = 1'h1;
      sda_low = 1'h1;
      #100 scl = 1'h0;
      #100;
      for (k = 15; k >= 0; k = k - 1) begin
        clk_bit(w[k]);
        if (k == 8 || k == 0) begin
          clk_bit(1'h1);
          ok = ok & ack;
        end
      end
      sda_low = 1'h1;
      #100 scl = 1'h1;
      #100 sda_low = 1'h0;
      #200;
    end
  endtask

  // clock held low past the bus timeout on purpose
  task stall(input integer ns);
    begin
      #10;
      sda_low = 1'h1;
      #100 scl = 1'h0;
      #(ns) scl = 1'h1;
      #100 sda_low = 1'h0;
      #200;
    end
  endtask
endmodule

// >>> tb/chg_supervisor_tb.sv
// self-checking bench for chg_supervisor: register bus and bus host
// assumes chg_smb_host as partner and the bound monitor
`timescale 1ns/1ps
`include "chg_map.vh"
module chg_supervisor_tb;
  reg         clk_sys, resetn, read, write, ok;
  reg         boost_output_enable_pin, hiz_pin_below_low;
  reg         hiz_pin_above_high, adapter_present, bat_above_uvlo;
  reg         charger_fault, input_overload, charge_current_zero;
  reg  [4:0]  address;
  reg  [3:0]  byteenable;
  reg  [31:0] writedata, q;
  reg  [8:0]  cell_cmp;
  wire [31:0] readdata;
  wire        waitrequest, irq, scl_in, sda_in, sda_out, sda_oe, host_low;
  wire        battery_pass_transistor, internal_regulator_output;
  wire        hiz_mode, vap_active, supplement_mode, charge_current_reduce;
  wire        minimum_system_voltage_loop;
  wire [11:0] vap_dac_code, sys_setpoint;
  wire [3:0]  monitor_enable;
  integer     err_total, n_checks, i;

  // open-drain data wire with pull-up
  assign sda_in = !(host_low | sda_oe);

  chg_smb_host u_chg_smb_host (.scl(scl_in), .sda_low(host_low),
    .sda_line(sda_in));

  // short counts keep the run brief
  chg_supervisor #(.TOUT_CYC(32'hC8), .WDT1_CYC(32'h12C),
    .WDT2_CYC(32'h258), .WDT3_CYC(32'h384)) u_chg_supervisor (
    .clk_sys, .resetn, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .irq, .scl_in, .sda_in,
    .sda_out, .sda_oe, .boost_output_enable_pin, .hiz_pin_below_low,
    .hiz_pin_above_high, .cell_cmp, .adapter_present, .bat_above_uvlo,
    .charger_fault, .input_overload, .charge_current_zero,
    .battery_pass_transistor, .internal_regulator_output, .hiz_mode,
    .vap_active, .supplement_mode, .charge_current_reduce,
    .minimum_system_voltage_loop, .vap_dac_code, .sys_setpoint,
    .monitor_enable);

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  // one access held until waitrequest is seen low
  task bus(input w, input [4:0] a, input [31:0] d);
    integer t;
    begin
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      t = 0;
      @(posedge clk_sys);
      while (waitrequest !== 1'h0 && t < 40) begin
        @(posedge clk_sys);
        t = t + 1;
      end
      if (t == 40) chk(32'h0, 32'h1);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clk_sys);
    end
  endtask

  // two-edge synchroniser latency plus margin
  task sett;
    repeat (6) @(posedge clk_sys);
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #1000000;
    err_total = err_total + 1;
    stop_test;
  end

  initial begin
    err_total = 0; n_checks = 0; resetn = 1'h0; read = 1'h0;
    write = 1'h0; address = 5'h0; byteenable = 4'hF; writedata = 32'h0;
    boost_output_enable_pin = 1'h0; hiz_pin_below_low = 1'h0;
    hiz_pin_above_high = 1'h1; adapter_present = 1'h0;
    bat_above_uvlo = 1'h1; charger_fault = 1'h0; input_overload = 1'h0;
    charge_current_zero = 1'h0; cell_cmp = 9'h0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    sett;
    bus(1'h0, `CHG_OFS_CTRL, 32'h0);
    chk(q, 32'h015);
    chk(internal_regulator_output, 32'h0);
    chk(battery_pass_transistor, 32'h1);
    // performance mode with all monitors
    bus(1'h1, `CHG_OFS_CTRL, 32'h3D4);
    sett;
    chk(internal_regulator_output, 32'h1);
    chk(monitor_enable, 32'hF);
    bus(1'h1, `CHG_OFS_CTRL, 32'h015);
    sett;
    chk(monitor_enable, 32'h0);
    // protection set-up: voltage, current, then minimum
    bus(1'h1, `CHG_OFS_VOUT, 32'h123);
    bus(1'h1, `CHG_OFS_IOUT, 32'h20);
    bus(1'h1, `CHG_OFS_VSYSMIN, 32'h456);
    boost_output_enable_pin <= 1'h1;
    bus(1'h1, `CHG_OFS_CTRL, 32'h011);
    sett;
    chk(vap_dac_code, 32'h1C3);
    chk(vap_active, 32'h1);
    chk(minimum_system_voltage_loop, 32'h1);
    chk(sys_setpoint, 32'h456);
    bus(1'h1, `CHG_OFS_CTRL, 32'h019);
    sett;
    chk(vap_dac_code, 32'h123);
    boost_output_enable_pin <= 1'h0;
    sett;
    chk(vap_active, 32'h0);
    boost_output_enable_pin <= 1'h1;
    sett;
    chk(vap_active, 32'h1);
    charger_fault <= 1'h1;
    sett;
    chk(vap_active, 32'h0);
    charger_fault <= 1'h0;
    bus(1'h0, `CHG_OFS_CTRL, 32'h0);
    chk(q[2], 32'h1);
    // overload with adapter present
    adapter_present <= 1'h1;
    input_overload <= 1'h1;
    sett;
    chk({supplement_mode, charge_current_reduce}, 32'h1);
    charge_current_zero <= 1'h1;
    sett;
    chk(supplement_mode & battery_pass_transistor, 32'h1);
    input_overload <= 1'h0;
    charge_current_zero <= 1'h0;
    // pin hysteresis, then the enable bit
    hiz_pin_above_high <= 1'h0;
    hiz_pin_below_low <= 1'h1;
    sett;
    chk(hiz_mode & battery_pass_transistor, 32'h1);
    hiz_pin_below_low <= 1'h0;
    sett;
    chk(hiz_mode, 32'h1);
    hiz_pin_above_high <= 1'h1;
    sett;
    chk(hiz_mode | battery_pass_transistor, 32'h0);
    bus(1'h1, `CHG_OFS_CTRL, 32'h017);
    sett;
    chk(hiz_mode & battery_pass_transistor, 32'h1);
    adapter_present <= 1'h0;
    // four, three, two, one cell, then the presence band
    for (i = 0; i < 4; i = i + 1) begin
      cell_cmp <= {1'h0, 8'hFF << (2 * i)};
      sett;
      bus(1'h0, `CHG_OFS_STATUS, 32'h0);
      chk(q[3:0], 12 - i);
    end
    cell_cmp <= 9'h080;
    sett;
    bus(1'h0, `CHG_OFS_STATUS, 32'h0);
    chk(q[3], 32'h1);
    // watchdog off; pending events read and cleared
    bus(1'h1, `CHG_OFS_CTRL, 32'h005);
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    chk(q[4], 32'h1);
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    chk(q[4:2], 32'h0);
    cell_cmp <= 9'h100;
    sett;
    chk(irq, 32'h0);
    bus(1'h1, `CHG_OFS_INT_MASK, 32'h04);
    sett;
    chk(irq, 32'h1);
    bus(1'h0, `CHG_OFS_STATUS, 32'h0);
    chk(q[3], 32'h0);
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    sett;
    chk(irq, 32'h0);
    // acknowledge, foreign address, stall and recovery
    u_chg_smb_host.frame(7'h2A, 8'h5A, ok);
    chk(ok, 32'h1);
    u_chg_smb_host.frame(7'h15, 8'h5A, ok);
    chk(ok, 32'h0);
    u_chg_smb_host.stall(11000);
    sett;
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    chk({sda_out, sda_oe, q[0]}, 32'h1);
    u_chg_smb_host.frame(7'h2A, 8'h5A, ok);
    chk(ok, 32'h1);
    @(posedge clk_sys); // bus requests start right after an edge
    // each period code, timed from the last acknowledged byte
    for (i = 1; i < 4; i = i + 1) begin
      bus(1'h1, `CHG_OFS_CTRL, 32'h005 | (i << 4));
      u_chg_smb_host.frame(7'h2A, 8'h01, ok);
      sett;
      bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
      repeat (300 * i - 40) @(posedge clk_sys);
      bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
      chk(q[1], 32'h0);
      repeat (80) @(posedge clk_sys);
      bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
      chk(q[1], 32'h1);
    end
    bus(1'h1, `CHG_OFS_CTRL, 32'h005);
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    repeat (1000) @(posedge clk_sys);
    bus(1'h0, `CHG_OFS_INT_STAT, 32'h0);
    chk(q[1], 32'h0);
    stop_test;
  end
endmodule
